// ===== voice_defs.vh
// constants for the single synthesizer voice: register map, control
// field positions, envelope timing table and clock rates.
// assumes inclusion by voice.v only; holds definitions, no logic.
`ifndef VOICE_DEFS_VH
`define VOICE_DEFS_VH

// ----------------------------------------
// register indices (byte address = 4 x index)
// ----------------------------------------
`define IDX_PITCH_LO 6'h00
`define IDX_PITCH_HI 6'h01
`define IDX_DUTY_LO 6'h02
`define IDX_DUTY_HI 6'h03
`define IDX_CONTROL 6'h04
`define IDX_RATES 6'h05
`define IDX_HOLD_END 6'h06
`define IDX_STATUS 6'h07
`define IDX_LAST 6'h07

// ----------------------------------------
// voice_control fields
// ----------------------------------------
`define CTL_TRIGGER 0
`define CTL_LOCK 1
`define CTL_RING 2
`define CTL_HOLD 3
`define CTL_TRI 4
`define CTL_SAW 5
`define CTL_PULSE 6
`define CTL_NOISE 7

// ----------------------------------------
// status layout
// ----------------------------------------
`define ST_ENV_LSB 0
`define ST_PHASE_LSB 8
`define ST_LOCK_BIT 13
`define ST_OSC_LSB 16

// ----------------------------------------
// clocks and envelope figures
// ----------------------------------------
`define CLK_HZ 50000000
`define PHI_HZ 1000000
`define MS_PER_S 1000
`define ENV_STEPS 255
`define ENV_PEAK 8'hff
`define SUS_STEP 8'h11
`define FALL_FACTOR 3
`define NOISE_SEED 23'h7ffff8
`define PW_FULL 12'hfff
`define RESET_VAL 8'h00

// attack full-rise times in ms, codes 0..15
`define ATK_MS_0 2
`define ATK_MS_1 8
`define ATK_MS_2 16
`define ATK_MS_3 24
`define ATK_MS_4 38
`define ATK_MS_5 56
`define ATK_MS_6 68
`define ATK_MS_7 80
`define ATK_MS_8 100
`define ATK_MS_9 250
`define ATK_MS_10 500
`define ATK_MS_11 800
`define ATK_MS_12 1000
`define ATK_MS_13 3000
`define ATK_MS_14 5000
`define ATK_MS_15 8000

`endif

// ===== voice.v
// one synthesizer voice: phase-accumulator oscillator, four waveforms,
// envelope generator, registers on an apb slave.
// assumes a same-clock partner voice drives partner_msb, and an apb
// master on mclk; reset is asynchronous and active high.
//
// Function
// - pitch word times clock over 2^24
// - duty from low byte plus high nibble
// - duty width sets pulse ratio, ends constant
// - trigger set starts attack, clear releases
// - lock bit hard-syncs to partner oscillator
// - product modulation replaces triangle with ring
// - hold bit zeroes oscillator, reseeds noise, holds pulse high
// - bits four to seven pick waveforms
// - noise steps at sixteen times oscillator rate
// - several waveforms combine by bitwise and
// - noise lock-up silent until hold/reset
// - amplitude set by envelope alone
// - rate register nibbles pick rise, fall
// - attack to peak, then decay to sustain
// - sixteen linear sustain levels, held while triggered
// - release rates equal decay rates
// - trigger changes act at any phase
// - rise times table, falls three times
// - times scale with voice clock rate
// - fall times are full peak-to-zero
`timescale 1ns/1ps
`include "voice_defs.vh"

module voice #(
  parameter TICK_DIV = `CLK_HZ / `PHI_HZ,
  parameter TICK_HZ = `PHI_HZ
) (
  input wire mclk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire partner_msb,
  output reg osc_msb,
  output reg [11:0] audio_out,
  output reg [7:0] env_level
);

  // ----------------------------------------
  // state encodings
  // ----------------------------------------
  localparam [4:0] PH_IDLE = 5'h01;
  localparam [4:0] PH_ATTACK = 5'h02;
  localparam [4:0] PH_DECAY = 5'h04;
  localparam [4:0] PH_SUSTAIN = 5'h08;
  localparam [4:0] PH_RELEASE = 5'h10;

  // ----------------------------------------
  // functions
  // ----------------------------------------
  function [13:0] rise_ms;
    input [3:0] code;
    begin
      case (code)
        4'h0: rise_ms = `ATK_MS_0;
        4'h1: rise_ms = `ATK_MS_1;
        4'h2: rise_ms = `ATK_MS_2;
        4'h3: rise_ms = `ATK_MS_3;
        4'h4: rise_ms = `ATK_MS_4;
        4'h5: rise_ms = `ATK_MS_5;
        4'h6: rise_ms = `ATK_MS_6;
        4'h7: rise_ms = `ATK_MS_7;
        4'h8: rise_ms = `ATK_MS_8;
        4'h9: rise_ms = `ATK_MS_9;
        4'ha: rise_ms = `ATK_MS_10;
        4'hb: rise_ms = `ATK_MS_11;
        4'hc: rise_ms = `ATK_MS_12;
        4'hd: rise_ms = `ATK_MS_13;
        4'he: rise_ms = `ATK_MS_14;
        default: rise_ms = `ATK_MS_15;
      endcase
    end
  endfunction

  // ticks per one-step change of the level; full range is ENV_STEPS
  function [16:0] step_ticks;
    input [3:0] code;
    input fall;
    reg [39:0] t;
    begin
      t = {26'h0, rise_ms(code)} * (TICK_HZ / `MS_PER_S);
      if (fall) begin
        t = t * `FALL_FACTOR;
      end
      t = t / `ENV_STEPS;
      if (t == 40'h0) begin
        t = 40'h1;
      end
      step_ticks = t[16:0];
    end
  endfunction

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0] pitch_word_low;
  reg [7:0] pitch_word_high;
  reg [7:0] duty_word_low;
  reg [7:0] duty_word_high;
  reg [7:0] voice_control;
  reg [7:0] rise_fall_rates;
  reg [7:0] hold_level_end_rate;

  wire [5:0] idx = paddr[7:2];
  wire mapped = (paddr[1:0] == 2'h0) && (idx <= `IDX_LAST);
  wire setup = psel && !penable;
  wire wr_en = psel && penable && pready && pwrite && !pslverr;

  wire [15:0] pitch_word = {pitch_word_high, pitch_word_low};
  wire [11:0] duty_word = {duty_word_high[3:0], duty_word_low};
  wire trigger = voice_control[`CTL_TRIGGER];
  wire lock_en = voice_control[`CTL_LOCK];
  wire product_modulation_enable = voice_control[`CTL_RING];
  wire osc_hold = voice_control[`CTL_HOLD];
  wire [3:0] rise_rate_code = rise_fall_rates[7:4];
  wire [3:0] fall_rate_code = rise_fall_rates[3:0];
  wire [3:0] hold_level_code = hold_level_end_rate[7:4];
  wire [3:0] end_rate_code = hold_level_end_rate[3:0];

  reg [23:0] acc_q;
  reg [22:0] lfsr_q;
  reg noise_lock_q;
  reg [4:0] phase_q;
  reg [16:0] rate_cnt_q;
  reg trig_q;
  reg partner_q;

  // ----------------------------------------
  // apb slave: answer in first access cycle
  // ----------------------------------------
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && (!mapped || (pwrite && idx == `IDX_STATUS));
      prdata <= 32'h0;
      // written registers are write-only and read as zero
      if (setup && !pwrite && mapped && idx == `IDX_STATUS) begin
        prdata[`ST_ENV_LSB +: 8] <= env_level;
        prdata[`ST_PHASE_LSB +: 5] <= phase_q;
        prdata[`ST_LOCK_BIT] <= noise_lock_q;
        prdata[`ST_OSC_LSB +: 8] <= acc_q[23:16];
      end
    end
  end

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      pitch_word_low <= `RESET_VAL;
      pitch_word_high <= `RESET_VAL;
      duty_word_low <= `RESET_VAL;
      duty_word_high <= `RESET_VAL;
      voice_control <= `RESET_VAL;
      rise_fall_rates <= `RESET_VAL;
      hold_level_end_rate <= `RESET_VAL;
    end else if (wr_en) begin
      case (idx)
        `IDX_PITCH_LO: pitch_word_low <= pwdata[7:0];
        `IDX_PITCH_HI: pitch_word_high <= pwdata[7:0];
        `IDX_DUTY_LO: duty_word_low <= pwdata[7:0];
        `IDX_DUTY_HI: duty_word_high <= pwdata[7:0];
        `IDX_CONTROL: voice_control <= pwdata[7:0];
        `IDX_RATES: rise_fall_rates <= pwdata[7:0];
        `IDX_HOLD_END: hold_level_end_rate <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // voice tick: the documented part clock, as an enable
  // ----------------------------------------
  reg [15:0] div_q;
  reg tick_q;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      div_q <= 16'h0;
      tick_q <= 1'b0;
    end else if (div_q == TICK_DIV[15:0] - 16'h1) begin
      div_q <= 16'h0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 16'h1;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // oscillator
  // ----------------------------------------
  // partner msb comes from same-clock logic, so no synchroniser
  wire partner_rise = partner_msb && !partner_q;
  wire noise_clk = acc_q[19];
  reg noise_clk_q;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      acc_q <= 24'h0;
      partner_q <= 1'b0;
    end else begin
      partner_q <= partner_msb;
      if (osc_hold) begin
        acc_q <= 24'h0;
      end else if (lock_en && partner_rise) begin
        // only the partner's top-bit rise matters, its other settings do not
        acc_q <= 24'h0;
      end else if (tick_q) begin
        acc_q <= acc_q + {8'h0, pitch_word};
      end
    end
  end

  // ----------------------------------------
  // waveforms
  // ----------------------------------------
  wire ring_msb = acc_q[23] ^ (product_modulation_enable & partner_msb);
  wire [11:0] wave_tri = {acc_q[22:12] ^ {11{ring_msb}}, 1'b0};
  wire [11:0] wave_saw = acc_q[23:12];
  reg pulse_lvl;
  wire [11:0] wave_pulse = {12{pulse_lvl}};
  wire [11:0] wave_noise = noise_lock_q ? 12'h0 :
    {lfsr_q[22], lfsr_q[20], lfsr_q[16], lfsr_q[13],
     lfsr_q[11], lfsr_q[7], lfsr_q[4], lfsr_q[2], 4'h0};

  always @* begin
    if (osc_hold) begin
      pulse_lvl = 1'b1;
    end else if (duty_word == 12'h0) begin
      pulse_lvl = 1'b0;
    end else if (duty_word == `PW_FULL) begin
      pulse_lvl = 1'b1;
    end else begin
      // high for duty/4096 of the period, 2048 gives a square
      pulse_lvl = acc_q[23:12] < duty_word;
    end
  end

  reg [11:0] wave;
  reg any_sel;

  always @* begin
    wave = 12'hfff;
    any_sel = 1'b0;
    if (voice_control[`CTL_TRI]) begin
      wave = wave & wave_tri;
      any_sel = 1'b1;
    end
    if (voice_control[`CTL_SAW]) begin
      wave = wave & wave_saw;
      any_sel = 1'b1;
    end
    if (voice_control[`CTL_PULSE]) begin
      wave = wave & wave_pulse;
      any_sel = 1'b1;
    end
    if (voice_control[`CTL_NOISE]) begin
      wave = wave & wave_noise;
      any_sel = 1'b1;
    end
    if (!any_sel) begin
      wave = 12'h0;
    end
  end

  // ----------------------------------------
  // noise generator
  // ----------------------------------------
  wire noise_mixed = voice_control[`CTL_NOISE] &&
    (voice_control[`CTL_TRI] || voice_control[`CTL_SAW] ||
     voice_control[`CTL_PULSE]);

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      lfsr_q <= `NOISE_SEED;
      noise_clk_q <= 1'b0;
      noise_lock_q <= 1'b0;
    end else begin
      noise_clk_q <= noise_clk;
      if (osc_hold) begin
        lfsr_q <= `NOISE_SEED;
        noise_lock_q <= 1'b0;
      end else if (noise_clk && !noise_clk_q) begin
        lfsr_q <= {lfsr_q[21:0], lfsr_q[22] ^ lfsr_q[17]};
        // and-ing with another wave to zero latches the noise output silent until hold
        if (noise_mixed && wave == 12'h0) begin
          noise_lock_q <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------
  // envelope generator
  // ----------------------------------------
  wire [7:0] sustain_lvl = hold_level_code * `SUS_STEP;
  reg [16:0] period;

  always @* begin
    case (phase_q)
      PH_ATTACK: period = step_ticks(rise_rate_code, 1'b0);
      PH_DECAY: period = step_ticks(fall_rate_code, 1'b1);
      PH_RELEASE: period = step_ticks(end_rate_code, 1'b1);
      default: period = 17'h1;
    endcase
  end

  wire step_due = tick_q && (rate_cnt_q >= period - 17'h1);

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      phase_q <= PH_IDLE;
      rate_cnt_q <= 17'h0;
      env_level <= 8'h0;
      trig_q <= 1'b0;
    end else begin
      trig_q <= trigger;
      if (trigger && !trig_q) begin
        // restart from the present level, not from zero
        phase_q <= PH_ATTACK;
        rate_cnt_q <= 17'h0;
      end else if (!trigger && trig_q) begin
        phase_q <= PH_RELEASE;
        rate_cnt_q <= 17'h0;
      end else if (tick_q) begin
        rate_cnt_q <= step_due ? 17'h0 : rate_cnt_q + 17'h1;
        case (phase_q)
          PH_ATTACK: begin
            if (env_level == `ENV_PEAK) begin
              phase_q <= PH_DECAY;
              rate_cnt_q <= 17'h0;
            end else if (step_due) begin
              env_level <= env_level + 8'h1;
            end
          end
          PH_DECAY: begin
            if (env_level <= sustain_lvl) begin
              phase_q <= PH_SUSTAIN;
            end else if (step_due) begin
              env_level <= env_level - 8'h1;
            end
          end
          PH_SUSTAIN: begin
            phase_q <= PH_SUSTAIN;
          end
          PH_RELEASE: begin
            if (env_level == 8'h0) begin
              phase_q <= PH_IDLE;
            end else if (step_due) begin
              env_level <= env_level - 8'h1;
            end
          end
          PH_IDLE: begin
            phase_q <= PH_IDLE;
          end
          default: begin
            phase_q <= PH_IDLE;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // output: waveform scaled by envelope only
  // ----------------------------------------
  wire [19:0] scaled = wave * env_level;

  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      audio_out <= 12'h0;
      osc_msb <= 1'b0;
    end else begin
      audio_out <= scaled[19:8];
      osc_msb <= acc_q[23];
    end
  end

endmodule

// ===== voice_properties.sv
// checker for the voice: apb answer timing, envelope and audio relations.
// assumes binding to voice; tracks control writes itself from apb ports.
`timescale 1ns/1ps
module voice_props (
  input wire mclk,
  input wire reset,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire partner_msb,
  input wire osc_msb,
  input wire [11:0] audio_out,
  input wire [7:0] env_level
);
  // ----
  // control shadow
  // ----
  reg [7:0] ctl_q;
  wire wr_ctl = psel && penable && pready && pwrite && !pslverr && paddr == 8'h10;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      ctl_q <= 8'h00;
    end else if (wr_ctl) begin
      ctl_q <= pwdata[7:0];
    end
  end
  default clocking dc @(posedge mclk); endclocking
  default disable iff (reset);
  // ----
  // properties
  // ----
  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready held too long");
  unmapped_error_a: assert property (pready && (paddr > 8'h1c || paddr[1:0] != 2'b00) |-> pslverr)
    else $error("bad address not refused");
  write_only_read_a: assert property (pready && !pwrite && paddr < 8'h1c && paddr[1:0] == 2'b00
    |-> prdata == 32'h0 && !pslverr) else $error("write-only register read back");
  silent_envelope_a: assert property (env_level == 8'h00 [*3] |-> audio_out == 12'h000)
    else $error("sound with zero envelope");
  audio_scaled_a: assert property (!$past(reset)
    |-> {1'b0, audio_out} < (({5'h00, $past(env_level)} + 13'h002) << 4))
    else $error("audio above envelope scale");
  env_single_step_a: assert property (!$past(reset) && env_level != $past(env_level)
    |-> env_level - $past(env_level) == 8'h01 || $past(env_level) - env_level == 8'h01)
    else $error("envelope jumped");
  release_falls_a: assert property (!ctl_q[0] [*3] ##0 env_level != $past(env_level)
    |-> env_level < $past(env_level)) else $error("envelope rose in release");
  hold_stops_osc_a: assert property (ctl_q[3] [*4] |-> !osc_msb)
    else $error("oscillator ran while held");
  no_wave_silent_a: assert property (ctl_q[7:4] == 4'h0 [*4] |-> audio_out == 12'h000)
    else $error("sound with no waveform");
endmodule

bind voice voice_props i_voice_props (.mclk(mclk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .partner_msb(partner_msb), .osc_msb(osc_msb),
  .audio_out(audio_out), .env_level(env_level));

// ===== partner_osc.sv
// partner oscillator: free-running 24-bit phase accumulator.
// assumes the bench sets a nonzero pitch; same clock as the voice.
`timescale 1ns/1ps
module partner_osc (
  input wire mclk,
  input wire reset,
  input wire [15:0] pitch,
  output reg partner_msb
);
  reg [23:0] acc_q;
  always @(posedge mclk or posedge reset) begin
    if (reset) begin
      acc_q <= 24'h000000;
      partner_msb <= 1'b0;
    end else begin
      acc_q <= acc_q + {8'h00, pitch}; // only its pitch shapes sync and ring
      partner_msb <= acc_q[23];
    end
  end
endmodule

// ===== testbench.sv
// self-checking bench for the voice: apb master tasks, partner oscillator,
// random pitches and envelope codes. assumes one 50 MHz clock.
`timescale 1ns/1ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  // shortened envelope clock; tolerance covers one-step quantisation
  localparam int THZ = 25000;
  int ms_t[16] = '{2, 8, 16, 24, 38, 56, 68, 80, 100, 250, 500, 800, 1000, 3000, 5000,
    8000};
  logic mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, rd, lfsr = 32'he286;
  logic [15:0] ppitch = 16'h4000;
  wire [31:0] prdata;
  wire pready, pslverr, partner_msb, osc_msb;
  wire [11:0] audio_out;
  wire [7:0] env_level;
  int n_errors = 0, comparisons = 0, t, t2, p, i;

  voice #(.TICK_DIV(1), .TICK_HZ(THZ)) i_voice (.mclk(mclk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .partner_msb(partner_msb), .osc_msb(osc_msb),
    .audio_out(audio_out), .env_level(env_level));
  partner_osc u_partner (.mclk(mclk), .reset(reset), .pitch(ppitch),
    .partner_msb(partner_msb));

  initial begin
    forever #10 mclk = ~mclk;
  end

  // ----
  // helpers
  // ----
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic near(int got, int exp);
    return (got - exp <= 800 + exp / 8) && (exp - got <= 800 + exp / 8);
  endfunction

  task automatic tally_and_finish();
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      n_errors++;
      tally_and_finish();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic wait_env(input logic [7:0] v, output int n);
    n = 0;
    while (env_level !== v) begin
      @(posedge mclk);
      n++;
      if (n > 60000) begin
        n_errors++;
        tally_and_finish();
      end
    end
  endtask

  // cycles until the next rising edge of own (s=0) or partner (s=1) top bit
  task automatic rise(input logic s, output int n);
    logic pm;
    n = 0;
    do begin
      pm = s ? partner_msb : osc_msb;
      @(posedge mclk);
      n++;
      if (n > 3000) begin
        n_errors++;
        tally_and_finish();
      end
    end while (!((s ? partner_msb : osc_msb) === 1'b1 && pm === 1'b0));
  endtask

  task automatic note(input int a, input int d, input int s, input int r);
    logic [7:0] l;
    apb(1, 8'h14, {24'h0, a[3:0], d[3:0]});
    apb(1, 8'h18, {24'h0, s[3:0], r[3:0]});
    apb(1, 8'h10, 32'h21);
    wait_env(8'hff, t);
    `CHK(near(t, ms_t[a] * THZ / 1000), 1'b1)
    wait_env(8'(s * 17), t);
    `CHK(near(t, 3 * ms_t[d] * THZ / 1000 * (255 - s * 17) / 255), 1'b1)
    repeat (40) @(posedge mclk);
    `CHK(env_level, 8'(s * 17))
    apb(1, 8'h08, 32'hff);
    apb(1, 8'h0c, 32'hff);
    apb(1, 8'h10, 32'h41);
    repeat (3) @(posedge mclk);
    `CHK(audio_out, 12'((4095 * s * 17) >> 8))
    apb(1, 8'h08, 32'h00);
    apb(1, 8'h0c, 32'hf0);
    apb(1, 8'h10, 32'h61);
    repeat (3) @(posedge mclk);
    `CHK(audio_out, 12'h000)
    apb(1, 8'h10, 32'h01);
    repeat (3) @(posedge mclk);
    `CHK(audio_out, 12'h000)
    apb(1, 8'h10, 32'h20);
    l = env_level;
    apb(1, 8'h10, 32'h21);
    @(posedge mclk);
    `CHK(env_level + 8'h04 >= l, 1'b1)
    l = env_level;
    repeat (20) @(posedge mclk);
    `CHK(env_level > l, 1'b1)
    wait_env(8'hff, t);
    wait_env(8'(s * 17), t);
    apb(1, 8'h10, 32'h20);
    wait_env(8'h00, t);
    `CHK(near(t, 3 * ms_t[r] * THZ / 1000 * s * 17 / 255), 1'b1)
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    @(posedge mclk);
    for (i = 0; i < 7; i++) begin
      apb(0, 8'(i * 4), 32'h0);
      `CHK({err, rd}, 33'h0)
    end
    apb(0, 8'h40, 32'h0);
    `CHK(err, 1'b1)
    apb(1, 8'h1c, 32'h0);
    `CHK(err, 1'b1)
    repeat (3) begin
      p = 32768 + rnd() % 32768;
      apb(1, 8'h00, p & 255);
      apb(1, 8'h04, p >> 8);
      rise(0, t);
      rise(0, t);
      `CHK(t * p > 32'h1000000 - p && t * p < 32'h1000000 + p, 1'b1)
    end
    apb(1, 8'h00, 32'h0);
    apb(1, 8'h04, 32'hf0);
    apb(1, 8'h10, 32'h02);
    for (i = 0; i < 3; i++) begin
      rise(1, t);
      rise(0, t2);
      if (i == 1) p = t2;
    end
    `CHK(t2, p)
    apb(1, 8'h10, 32'h48);
    repeat (600) @(posedge mclk);
    apb(0, 8'h1c, 32'h0);
    `CHK({osc_msb, rd[23:16]}, 9'h0)
    apb(1, 8'h10, 32'h00);
    repeat (2) note(rnd() % 8, rnd() % 8, rnd() % 14 + 1, rnd() % 8);
    tally_and_finish();
  end
endmodule
